// File: rtl/hbg_gate_drive.sv
// gate drive logic for a triple half-bridge with lockouts and overcurrent shutdown
`timescale 1ns/1ps
module hbg_gate_drive #(
    parameter int PHASES        = hbg_pkg::NUM_PHASES,
    parameter int DEAD_CYCLES   = hbg_pkg::DEAD_CYCLES,
    parameter int GLITCH_CYCLES = hbg_pkg::GLITCH_CYCLES
) (
    input  wire logic                              clk_in,
    input  wire logic                              sys_rst_in,
    input  wire logic                              gate_activation_in,
    input  wire hbg_pkg::hbg_cmd_t [PHASES-1:0]    cmd_in,
    input  wire logic                              supply_lockout_in,
    input  wire logic [PHASES-1:0]                 bootstrap_lockout_in,
    input  wire logic                              sense_over_in,
    input  wire logic                              sense_clear_in,
    input  wire logic                              timer_unlatch_in,
    input  wire logic                              timer_restart_in,
    output hbg_pkg::hbg_gate_t [PHASES-1:0]        gate_out,
    output logic                                   protection_alert_n_out,
    output logic                                   disable_timer_pin_out,
    output logic                                   disable_timer_pin_oe_out
);
    localparam logic [hbg_pkg::CNT_W-1:0] DEAD_LEN   = hbg_pkg::CNT_W'(DEAD_CYCLES);
    // filter near 300 ns
    // the trip lands one sample past the count, so 15 cycles at 50 MHz gives 320 ns
    localparam logic [hbg_pkg::CNT_W-1:0] GLITCH_LEN = hbg_pkg::CNT_W'(GLITCH_CYCLES);
    // check helpers: saturation points of the run and wait counters
    localparam logic [hbg_pkg::CNT_W-1:0] COMP_SAT   = GLITCH_LEN + 8'h01;
    localparam logic [hbg_pkg::CNT_W-1:0] WAIT_LEN   = DEAD_LEN + 8'h02;

    hbg_pkg::hbg_sd_state_t         sd_state_reg;
    logic [hbg_pkg::CNT_W-1:0]      glitch_cnt_reg;
    logic                           trip_pulse;
    logic                           shutdown_active;
    logic                           comp_raw;
    logic [hbg_pkg::CNT_W-1:0]      comp_run_reg;

    // comparator gated
    // comparator output is ignored while the main supply is locked out
    assign comp_raw = sense_over_in & ~supply_lockout_in;

    // glitch filter count
    // counts consecutive high cycles; any low sample restarts the filter
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !comp_raw) begin
            glitch_cnt_reg <= hbg_pkg::CNT_ZERO;
        end else if (glitch_cnt_reg != GLITCH_LEN) begin
            glitch_cnt_reg <= glitch_cnt_reg + 8'h01;
        end
    end

    // filter length parameter
    // trip once the pulse has outlasted the filter length
    assign trip_pulse = comp_raw && (glitch_cnt_reg == GLITCH_LEN);

    // comparator run length for the filter checks; kept apart from the filter
    // counter so the checks do not lean on the logic they judge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !comp_raw) begin
            comp_run_reg <= hbg_pkg::CNT_ZERO;
        end else if (comp_run_reg != COMP_SAT) begin
            comp_run_reg <= comp_run_reg + 8'h01;
        end
    end

    // shutdown sequencing
    // discharge until sense clears and pin below unlatch, then wait for restart
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sd_state_reg <= hbg_pkg::SD_IDLE;
        end else begin
            unique case (sd_state_reg)
                hbg_pkg::SD_IDLE: begin
                    if (trip_pulse) begin
                        sd_state_reg <= hbg_pkg::SD_DISCHARGE;
                    end
                end
                hbg_pkg::SD_DISCHARGE: begin
                    if (sense_clear_in && timer_unlatch_in) begin
                        sd_state_reg <= hbg_pkg::SD_RECHARGE;
                    end
                end
                hbg_pkg::SD_RECHARGE: begin
                    // restart at threshold
                    // a new trip during recharge restarts the discharge
                    if (trip_pulse) begin
                        sd_state_reg <= hbg_pkg::SD_DISCHARGE;
                    end else if (timer_restart_in) begin
                        sd_state_reg <= hbg_pkg::SD_IDLE;
                    end
                end
                default: begin
                    sd_state_reg <= hbg_pkg::SD_IDLE;
                end
            endcase
        end
    end

    // immediate gate kill
    // the trip itself kills gates at the next edge, not waiting on the pin network
    assign shutdown_active = trip_pulse || (sd_state_reg != hbg_pkg::SD_IDLE);

    // pin discharge switch
    // open-drain: drive low only while discharging, output data is always zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            disable_timer_pin_oe_out <= 1'b0;
            disable_timer_pin_out    <= 1'b0;
        end else begin
            disable_timer_pin_out    <= 1'b0;
            disable_timer_pin_oe_out <= trip_pulse ||
                (sd_state_reg == hbg_pkg::SD_DISCHARGE &&
                 !(sense_clear_in && timer_unlatch_in));
        end
    end

    // alert on lockout
    // alert is pure indication; nothing inside reads it back
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            protection_alert_n_out <= 1'b0;
        end else begin
            protection_alert_n_out <= !(supply_lockout_in || shutdown_active);
        end
    end

    // per-phase decode, interlock and dead interval
    genvar p;
    generate
        for (p = 0; p < PHASES; p++) begin : g_phase
            logic                      req_low;
            logic                      req_high;
            logic                      want_low;
            logic                      want_high;
            logic                      high_armed_reg;
            logic                      high_req_prev_reg;
            logic [hbg_pkg::CNT_W-1:0] dead_cnt_reg;
            logic                      last_low_reg;
            logic                      kill;
            logic [hbg_pkg::CNT_W-1:0] since_low_reg;
            logic [hbg_pkg::CNT_W-1:0] since_high_reg;
            logic [hbg_pkg::CNT_W-1:0] low_wait_reg;
            logic [hbg_pkg::CNT_W-1:0] high_wait_reg;

            assign req_low  = gate_activation_in && !cmd_in[p].low_side_cmd_n;
            assign req_high = gate_activation_in && !cmd_in[p].high_side_cmd_n;

            assign kill = supply_lockout_in || shutdown_active;

            // bootstrap rearm
            // held requests are not resumed; only a new high request or a supply lockout rearms
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    high_armed_reg    <= 1'b1;
                    high_req_prev_reg <= 1'b0;
                end else begin
                    high_req_prev_reg <= req_high;
                    if (bootstrap_lockout_in[p] && !supply_lockout_in) begin
                        high_armed_reg <= 1'b0;
                    end else if (supply_lockout_in || (req_high && !high_req_prev_reg)) begin
                        high_armed_reg <= 1'b1;
                    end
                end
            end

            assign want_low  = req_low && !req_high && !kill;
            assign want_high = req_high && !req_low && !kill &&
                               !bootstrap_lockout_in[p] && high_armed_reg;

            // dead interval counter
            // held at zero while either gate is on; reaching length allows the other side
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    dead_cnt_reg <= DEAD_LEN;
                    last_low_reg <= 1'b0;
                end else if (gate_out[p].low_gate || gate_out[p].high_gate) begin
                    dead_cnt_reg <= hbg_pkg::CNT_ZERO;
                    last_low_reg <= gate_out[p].low_gate;
                end else if (dead_cnt_reg != DEAD_LEN) begin
                    dead_cnt_reg <= dead_cnt_reg + 8'h01;
                end
            end

            // no extra delay
            // the gap counts from turn-off, so an external gap already covers it
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    gate_out[p] <= '0;
                end else begin
                    gate_out[p].low_gate  <= want_low &&
                        (gate_out[p].low_gate || last_low_reg || dead_cnt_reg == DEAD_LEN);
                    gate_out[p].high_gate <= want_high &&
                        (gate_out[p].high_gate || !last_low_reg || dead_cnt_reg == DEAD_LEN);
                end
            end

            // per-side off time, saturating at the dead length; kept per side so the
            // dead checks do not reuse the shared counter they are meant to judge
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    since_low_reg  <= DEAD_LEN;
                    since_high_reg <= DEAD_LEN;
                end else begin
                    if (gate_out[p].low_gate) begin
                        since_low_reg <= hbg_pkg::CNT_ZERO;
                    end else if (since_low_reg != DEAD_LEN) begin
                        since_low_reg <= since_low_reg + 8'h01;
                    end
                    if (gate_out[p].high_gate) begin
                        since_high_reg <= hbg_pkg::CNT_ZERO;
                    end else if (since_high_reg != DEAD_LEN) begin
                        since_high_reg <= since_high_reg + 8'h01;
                    end
                end
            end

            // cycles a lone low request has been held, for the follow check
            always_ff @(posedge clk_in) begin
                if (sys_rst_in || !want_low) begin
                    low_wait_reg <= hbg_pkg::CNT_ZERO;
                end else if (low_wait_reg != WAIT_LEN) begin
                    low_wait_reg <= low_wait_reg + 8'h01;
                end
            end

            // cycles a lone high request has been held, for the follow check
            always_ff @(posedge clk_in) begin
                if (sys_rst_in || !want_high) begin
                    high_wait_reg <= hbg_pkg::CNT_ZERO;
                end else if (high_wait_reg != WAIT_LEN) begin
                    high_wait_reg <= high_wait_reg + 8'h01;
                end
            end

            // never both gates high
            chk_gate_interlock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                !(gate_out[p].low_gate && gate_out[p].high_gate))
                else $error("both gates of one phase high");
            // either gate turning off keeps the other gate off for two samples
            chk_dead_low_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                $fell(gate_out[p].low_gate) |-> !gate_out[p].high_gate [*2])
                else $error("dead interval violated low to high");
            chk_dead_high_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                $fell(gate_out[p].high_gate) |-> !gate_out[p].low_gate [*2])
                else $error("dead interval violated high to low");
            // bootstrap lockout blocks high gate next cycle
            chk_boot_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                bootstrap_lockout_in[p] |=> !gate_out[p].high_gate)
                else $error("high gate on during bootstrap lockout");
            // truth table: lone low request reaches gate within the dead interval plus two cycles
            chk_low_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                low_wait_reg == WAIT_LEN |-> gate_out[p].low_gate)
                else $error("low request not honoured");
            // lone high request reaches its gate within the dead interval plus two cycles
            chk_high_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                high_wait_reg == WAIT_LEN |-> gate_out[p].high_gate)
                else $error("high request not honoured");
            // the complementary gate rises only after the full dead interval
            chk_dead_span_lh: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                $rose(gate_out[p].high_gate) |-> since_low_reg >= DEAD_LEN)
                else $error("low to high gap shorter than dead interval");
            chk_dead_span_hl: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                $rose(gate_out[p].low_gate) |-> since_high_reg >= DEAD_LEN)
                else $error("high to low gap shorter than dead interval");
            // a high request held across bootstrap lockout is not resumed
            chk_boot_rearm: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                $fell(bootstrap_lockout_in[p]) && !$past(supply_lockout_in)
                    |=> !gate_out[p].high_gate)
                else $error("high gate resumed a held request");
            // disabled input gives low gates
            chk_enable_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                !gate_activation_in |=> !gate_out[p].low_gate && !gate_out[p].high_gate)
                else $error("gate on with enable low");
            cov_high_on: cover property (@(posedge clk_in) disable iff (sys_rst_in)
                $rose(gate_out[p].high_gate));
        end
    endgenerate

    // supply lockout kills every gate and holds alert
    chk_supply_kill: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        supply_lockout_in |=> (gate_out == '0) && !protection_alert_n_out)
        else $error("output active during supply lockout");
    // short pulses never trip
    chk_glitch_short: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        comp_raw && comp_run_reg < GLITCH_LEN |-> !trip_pulse)
        else $error("short comparator pulse caused shutdown");
    // a pulse one sample past the filter length trips
    chk_glitch_long: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        comp_raw && comp_run_reg == GLITCH_LEN |-> trip_pulse)
        else $error("long comparator pulse did not trip");
    // trip kills gates, pulls alert and drives pin next cycle
    chk_trip_kill: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        trip_pulse |=> gate_out == '0 && !protection_alert_n_out
            && disable_timer_pin_oe_out)
        else $error("trip did not shut down");
    // no comparator action during lockout
    chk_comp_disabled: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        supply_lockout_in && sd_state_reg == hbg_pkg::SD_IDLE
            |=> !disable_timer_pin_oe_out)
        else $error("comparator active during lockout");
    // pin released only after both conditions
    chk_pin_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(disable_timer_pin_oe_out)
            |-> $past(sense_clear_in) && $past(timer_unlatch_in))
        else $error("pin released early");
    // gates stay off through the whole disable time, discharge and recharge alike
    chk_shutdown_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sd_state_reg != hbg_pkg::SD_IDLE |=> gate_out == '0)
        else $error("gate on during disable time");
    // once restart is reached and nothing else holds it, the alert releases
    chk_restart_alert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (sd_state_reg == hbg_pkg::SD_RECHARGE && timer_restart_in && !trip_pulse)
            ##1 (!supply_lockout_in && !trip_pulse) |=> protection_alert_n_out)
        else $error("alert held after restart");

    cov_trip: cover property (@(posedge clk_in) trip_pulse);
    cov_restart: cover property (@(posedge clk_in)
        sd_state_reg == hbg_pkg::SD_RECHARGE ##1 sd_state_reg == hbg_pkg::SD_IDLE);
    cov_lockout_exit: cover property (@(posedge clk_in) $fell(supply_lockout_in));
endmodule

// File: rtl/hbg_pkg.sv
// package of constants and carrier types for the half-bridge gate drive logic
package hbg_pkg;
    // number of half-bridge phases
    localparam int NUM_PHASES = 3;
    // clock rate in kHz (50 MHz)
    localparam int CLK_KHZ = 50000;
    // dead interval target in ns, rounded up to whole cycles
    localparam int DEAD_INTERVAL_NS = 300;
    localparam int DEAD_CYCLES =
        (DEAD_INTERVAL_NS * CLK_KHZ + 999999) / 1000000;
    // glitch filter target in ns, rounded up to whole cycles
    localparam int GLITCH_FILTER_NS = 300;
    localparam int GLITCH_CYCLES =
        (GLITCH_FILTER_NS * CLK_KHZ + 999999) / 1000000;
    // counter width shared by both timers
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // per-phase command pair, active-low as at the pins
    typedef struct packed {
        logic low_side_cmd_n;
        logic high_side_cmd_n;
    } hbg_cmd_t;

    // per-phase gate pair
    typedef struct packed {
        logic low_gate;
        logic high_gate;
    } hbg_gate_t;

    // overcurrent shutdown sequencing states
    typedef enum logic [1:0] {
        SD_IDLE      = 2'b00,
        SD_DISCHARGE = 2'b01,
        SD_RECHARGE  = 2'b10
    } hbg_sd_state_t;
endpackage

// File: test/hbg_pwm_model.sv
// pwm controller model that drives the enable and the active-low gate commands
`timescale 1ns/1ps
module hbg_pwm_model (
    input  wire logic                                    clk_in,
    output logic                                         enable_out,
    output hbg_pkg::hbg_cmd_t [hbg_pkg::NUM_PHASES-1:0]  cmd_out
);
    // start disabled with no request, as a timer not yet configured would
    initial begin
        enable_out = 1'b0;
        cmd_out    = {hbg_pkg::NUM_PHASES{2'b11}};
    end

    // changes land just after an edge so the block never samples them mid-change
    task automatic set_phase(input int p, input logic low_n, input logic high_n);
        @(posedge clk_in);
        #1;
        cmd_out[p].low_side_cmd_n  = low_n;
        cmd_out[p].high_side_cmd_n = high_n;
    endtask

    // enable high permits switching, commands are active low
    task automatic set_all(input logic en, input logic low_n, input logic high_n);
        @(posedge clk_in);
        #1;
        enable_out = en;
        cmd_out    = {hbg_pkg::NUM_PHASES{low_n, high_n}};
    endtask

    // complementary switch: gap 0 swaps at once (prompt), else both off for gap cycles (slow)
    task automatic swap(input int p, input logic to_high, input int gap);
        if (gap == 0) begin
            set_phase(p, to_high, !to_high);
        end else begin
            set_phase(p, 1'b1, 1'b1);
            repeat (gap - 1) @(posedge clk_in);
            set_phase(p, to_high, !to_high);
        end
    endtask
endmodule

// File: test/test_hbg_gate_drive.sv
// self-checking bench for the half-bridge gate drive logic
`timescale 1ns/1ps
module test_hbg_gate_drive;
    // short counts keep the run brief; expectations derive from these
    localparam int DEAD_C   = 2;
    localparam int GLITCH_C = 2;
    typedef struct packed {
        logic en;
        logic ln;
        logic hn;
        logic [7:0] exp;
    } hbg_row_t;
    logic                                        clk_in = 1'b0;
    logic                                        sys_rst_in = 1'b1;
    logic                                        enable;
    hbg_pkg::hbg_cmd_t [hbg_pkg::NUM_PHASES-1:0] cmd;
    logic                                        supply_lockout = 1'b0;
    logic [hbg_pkg::NUM_PHASES-1:0]              boot_lockout = '0;
    logic                                        sense_over = 1'b0;
    logic                                        sense_clear = 1'b0;
    logic                                        unlatch = 1'b0;
    logic                                        restart = 1'b0;
    hbg_pkg::hbg_gate_t [hbg_pkg::NUM_PHASES-1:0] gate_out;
    logic                                        alert_n;
    logic                                        pin_out;
    logic                                        pin_oe;
    int                                          num_errors = 0;
    int                                          num_checks = 0;
    int                                          gap_run = 0;
    int                                          last_gap = 0;
    // rows drive all phases alike; expected gates are {low,high} per phase
    hbg_row_t rows [6] = '{'{1'b0, 1'b0, 1'b1, 8'h00}, '{1'b0, 1'b1, 1'b0, 8'h00},
                           '{1'b1, 1'b1, 1'b1, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'h2A},
                           '{1'b1, 1'b1, 1'b0, 8'h15}, '{1'b1, 1'b0, 1'b0, 8'h00}};

    hbg_gate_drive #(.PHASES(hbg_pkg::NUM_PHASES), .DEAD_CYCLES(DEAD_C),
        .GLITCH_CYCLES(GLITCH_C)) hbg_gate_drive_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .gate_activation_in(enable),
        .cmd_in(cmd), .supply_lockout_in(supply_lockout), .bootstrap_lockout_in(boot_lockout),
        .sense_over_in(sense_over), .sense_clear_in(sense_clear),
        .timer_unlatch_in(unlatch), .timer_restart_in(restart), .gate_out(gate_out),
        .protection_alert_n_out(alert_n), .disable_timer_pin_out(pin_out),
        .disable_timer_pin_oe_out(pin_oe));
    hbg_pwm_model hbg_pwm_model_inst (.clk_in(clk_in), .enable_out(enable), .cmd_out(cmd));

    // 50 MHz clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end

    // length of the last stretch with both gates of phase 0 off
    always @(posedge clk_in) begin
        if (gate_out[0] === 2'b00) begin
            gap_run++;
        end else begin
            if (gap_run != 0) last_gap = gap_run;
            gap_run = 0;
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic edge1();
        @(posedge clk_in);
        #1;
    endtask
    // sample well after the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 180 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        close_out();
    end

    initial begin
        cyc(15);
        chk("reset_gates", 8'(gate_out), 8'h00);
        chk("reset_alert", 8'(alert_n), 8'h00);
        chk("reset_oe", 8'(pin_oe), 8'h00);
        edge1();
        sys_rst_in = 1'b0;
        cyc(2);
        chk("idle_alert", 8'(alert_n), 8'h01);
        $display("test reset done");
        foreach (rows[i]) begin
            hbg_pwm_model_inst.set_all(rows[i].en, rows[i].ln, rows[i].hn);
            cyc(DEAD_C + 6);
            chk("row_gates", 8'(gate_out), rows[i].exp);
        end
        $display("test truth rows done");
        hbg_pwm_model_inst.set_all(1'b1, 1'b0, 1'b1);
        cyc(8);
        last_gap = 0;
        hbg_pwm_model_inst.swap(0, 1'b1, 0);
        cyc(8);
        chk("dead_min", 8'(last_gap >= DEAD_C), 8'h01);
        chk("dead_gates", 8'(gate_out), 8'h29);
        last_gap = 0;
        hbg_pwm_model_inst.swap(0, 1'b0, DEAD_C + 4);
        cyc(8);
        chk("gap_follow", 8'(last_gap), 8'(DEAD_C + 4));
        chk("gap_gates", 8'(gate_out), 8'h2A);
        $display("test dead interval done");
        hbg_pwm_model_inst.set_all(1'b1, 1'b1, 1'b0);
        cyc(8);
        edge1();
        supply_lockout = 1'b1;
        sense_over = 1'b1;
        cyc(3);
        chk("uv_gates", 8'(gate_out), 8'h00);
        chk("uv_alert", 8'(alert_n), 8'h00);
        cyc(6);
        chk("uv_no_trip", 8'(pin_oe), 8'h00);
        edge1();
        supply_lockout = 1'b0;
        sense_over = 1'b0;
        cyc(3);
        chk("uv_resume", 8'(gate_out), 8'h15);
        chk("uv_alert_off", 8'({alert_n, pin_oe}), 8'h02);
        $display("test supply lockout done");
        edge1();
        boot_lockout = 3'b010;
        cyc(3);
        chk("boot_gates", 8'(gate_out), 8'h11);
        edge1();
        boot_lockout = 3'b000;
        cyc(5);
        chk("boot_hold", 8'(gate_out), 8'h11);
        hbg_pwm_model_inst.set_phase(1, 1'b1, 1'b1);
        hbg_pwm_model_inst.set_phase(1, 1'b1, 1'b0);
        cyc(DEAD_C + 6);
        chk("boot_rearm", 8'(gate_out), 8'h15);
        $display("test bootstrap lockout done");
        edge1();
        sense_over = 1'b1;
        repeat (GLITCH_C) edge1();
        sense_over = 1'b0;
        cyc(4);
        chk("glitch_ignored", 8'({gate_out, alert_n, pin_oe}), 8'h56);
        edge1();
        sense_over = 1'b1;
        cyc(GLITCH_C + 2);
        chk("trip_gates", 8'(gate_out), 8'h00);
        chk("trip_pin", 8'({alert_n, pin_oe, pin_out}), 8'h02);
        edge1();
        sense_over = 1'b0;
        unlatch = 1'b1;
        cyc(4);
        chk("hold_no_clear", 8'(pin_oe), 8'h01);
        edge1();
        sense_clear = 1'b1;
        unlatch = 1'b0;
        cyc(4);
        chk("hold_no_unlatch", 8'(pin_oe), 8'h01);
        edge1();
        unlatch = 1'b1;
        cyc(2);
        chk("recharge", 8'({gate_out, alert_n, pin_oe}), 8'h00);
        edge1();
        unlatch = 1'b0;
        restart = 1'b1;
        cyc(2);
        chk("restart", 8'({gate_out, alert_n, pin_oe}), 8'h56);
        $display("test overcurrent shutdown done");
        // mid-run reset with high requests standing, then release
        edge1();
        sys_rst_in = 1'b1;
        cyc(2);
        chk("rerst_outputs", 8'({gate_out, alert_n, pin_oe}), 8'h00);
        edge1();
        sys_rst_in = 1'b0;
        cyc(2);
        chk("rerst_resume", 8'({gate_out, alert_n, pin_oe}), 8'h56);
        $display("test mid-run reset done");
        close_out();
    end
endmodule
